// ---- design/nvsw_defines.vh ----
`ifndef NVSW_DEFINES_VH
`define NVSW_DEFINES_VH
// ==========================================================
// register map (byte offsets on the 8-bit paddr)
`define NVSW_CTRL_OFS      8'h00
`define NVSW_STAT_OFS      8'h04
`define NVSW_RAM_REGION    2'h1
`define NVSW_NV_REGION     2'h2
`define NVSW_CTRL_RST      1'h0
// ==========================================================
// field positions
`define NVSW_CTRL_INH_BIT  0
`define NVSW_STAT_WEL_BIT  0
`define NVSW_STAT_PRL_BIT  1
`define NVSW_STAT_PWR_BIT  2
`define NVSW_STAT_SAV_BIT  3
`define NVSW_STAT_RST_BIT  4
// ==========================================================
// serial opcodes, low three bits of the instruction
`define NVSW_OP_CLEAR_WRITE_LATCH 3'h0
`define NVSW_OP_SAVE              3'h1
`define NVSW_OP_SET_WRITE_LATCH   3'h4
`define NVSW_OP_RESTORE           3'h5
// ==========================================================
// timing
// 5 ms at 20 MHz, sized to the 17-bit save counter
`define NVSW_SAVE_CYCLES   17'h186A0
`define NVSW_SYNC_RST      5'h18
`endif

// ---- design/nvsw_sync.v ----
`timescale 1ns/1ns
`include "nvsw_defines.vh"
module nvsw_sync
(
   input  wire       i_clk,    // system clock
   input  wire       i_reset,  // async reset, active high
   input  wire [4:0] i_async,  // raw pins
   output wire [4:0] o_level   // filtered levels
);
   reg [4:0] stage1;
   reg [4:0] stage2;
   reg [4:0] stage3;
   reg [4:0] level;
   // pin idle levels, so no false request follows reset
   localparam [4:0] RST_LVL = `NVSW_SYNC_RST;
   genvar g;
   generate
      for (g = 0; g < 5; g = g + 1)
      begin : g_bit
         always @(posedge i_clk or posedge i_reset)
         begin
            if (i_reset)
            begin
               stage1[g] <= RST_LVL[g];
               stage2[g] <= RST_LVL[g];
               stage3[g] <= RST_LVL[g];
               level[g]  <= RST_LVL[g];
            end
            else
            begin
               stage1[g] <= i_async[g];
               stage2[g] <= stage1[g];
               stage3[g] <= stage2[g];
               // change only counts once stage two and three agree
               if (stage2[g] == stage3[g])
                  level[g] <= stage3[g];
            end
         end
      end
   endgenerate
   assign o_level = level;
endmodule // nvsw_sync

// ---- design/nvsw_top.v ----
// Function
// RL1: reset clears the write latch so no save can start.
// RL2: prior-restore latch sets only when an explicit restore completes.
// RL3: after reset the whole nonvolatile array is copied into RAM.
// RL4: the power-up copy leaves the prior-restore latch cleared.
// RL5: serial instructions arriving during the power-up copy are ignored.
// RL6: host waits the power-up read delay before any operation.
// RL7: reset leaves both latches cleared.
// RL8: host should clear the write latch after writes and saves.
// RL9: a timed save lasts up to the save time.
// RL10: host waits the save time before clearing the write latch.
// RL11: no save while restore pin low or chip select low.
// RL12: host waits read and write power-up delays after supply stable.
// RL13: save starts on command or low save pin with both latches set.
// RL14: save completion clears the write latch.
// RL15: opcodes clear 000, save 001, set 100, restore 101, msb one.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "nvsw_defines.vh"
module nvsw_top
#(
   parameter [16:0] P_SAVE_CYCLES = `NVSW_SAVE_CYCLES
)
(
   input  wire        I_SYS_CLK,             // 20 MHz clock
   input  wire        I_RESET,               // async reset = power-up
   input  wire        I_CHIP_SELECT,         // pin, high selects
   input  wire        I_SERIAL_SHIFT_CLOCK,  // pin, rising edge shifts
   input  wire        I_SERIAL_IN,           // pin, instruction bits
   input  wire        I_SAVE_N,              // pin, low requests save
   input  wire        I_RESTORE_N,           // pin, low requests restore
   input  wire        I_PSEL,                // apb select
   input  wire        I_PENABLE,             // apb enable
   input  wire        I_PWRITE,              // apb direction
   input  wire [7:0]  I_PADDR,               // apb byte address
   input  wire [31:0] I_PWDATA,              // apb write data
   output wire        O_PREADY,              // apb ready
   output wire [31:0] O_PRDATA,              // apb read data
   output wire        O_PSLVERR,             // apb error
   output wire        O_WRITE_LATCH,         // write latch state
   output wire        O_PRIOR_RESTORE,       // prior-restore latch state
   output wire        O_RESTORE_BUSY,        // restore copy running
   output wire        O_SAVE_BUSY            // save running
);
   localparam [1:0] ST_IDLE    = 2'h0;
   localparam [1:0] ST_RESTORE = 2'h1;
   localparam [1:0] ST_SAVE    = 2'h2;
   localparam [1:0] ST_WAIT    = 2'h3;

   reg  [15:0] ram_mem [0:15];
   reg  [15:0] nv_mem  [0:15];
   wire [4:0]  pins;
   reg  [1:0]  state;
   reg  [3:0]  word_idx;
   reg  [16:0] wait_cnt;
   reg         powerup;
   reg         wel;
   reg         prl;
   reg         save_inhibit;
   reg         sk_prev;
   reg         started;
   reg         shift_done;
   reg  [2:0]  bit_cnt;
   reg  [6:0]  shreg;
   reg         pready;
   reg  [31:0] prdata;
   reg         pslverr;
   reg         restore_busy;
   reg         save_busy;
   reg  [31:0] next_prdata;
   reg         next_err;

   // ==========================================================
   // pin synchronisers
   nvsw_sync u_sync
   (
      .i_clk   (I_SYS_CLK),
      .i_reset (I_RESET),
      .i_async ({I_RESTORE_N, I_SAVE_N, I_SERIAL_IN,
                 I_SERIAL_SHIFT_CLOCK, I_CHIP_SELECT}),
      .o_level (pins)
   );
   wire cs_f      = pins[0];
   wire sk_f      = pins[1];
   wire si_f      = pins[2];
   wire save_n_f  = pins[3];
   wire restore_n = pins[4];
   wire sk_rise   = sk_f & ~sk_prev;

   // ==========================================================
   // serial instruction shifter
   wire [2:0] opcode   = {shreg[1:0], si_f};
   wire       cmd_fire = cs_f & sk_rise & started & ~shift_done &
                         (bit_cnt == 3'h7) & (state == ST_IDLE); // RL5
   wire cmd_save  = cmd_fire & (opcode == `NVSW_OP_SAVE);            // RL15
   wire cmd_set   = cmd_fire & (opcode == `NVSW_OP_SET_WRITE_LATCH); // RL15
   wire cmd_clear = cmd_fire & (opcode == `NVSW_OP_CLEAR_WRITE_LATCH);
   wire cmd_rest  = cmd_fire & (opcode == `NVSW_OP_RESTORE);         // RL15

   always @(posedge I_SYS_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         sk_prev    <= 1'h0;
         started    <= 1'h0;
         shift_done <= 1'h0;
         bit_cnt    <= 3'h0;
         shreg      <= 7'h00;
      end
      else
      begin
         sk_prev <= sk_f;
         if (!cs_f)
         begin
            started    <= 1'h0;
            shift_done <= 1'h0;
            bit_cnt    <= 3'h0;
         end
         else if (sk_rise && !started)
         begin
            // leading zeros are skipped until the start bit
            if (si_f)
            begin
               started <= 1'h1;
               bit_cnt <= 3'h1;
               shreg   <= 7'h01;
            end
         end
         else if (sk_rise && !shift_done)
         begin
            shreg   <= {shreg[5:0], si_f};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
               shift_done <= 1'h1;
         end
      end
   end

   // ==========================================================
   // transfer sequencer
   wire save_go = wel & prl & cs_f & restore_n & ~save_inhibit &
                  (cmd_save | ~save_n_f);                 // RL11 RL13
   wire last    = (word_idx == 4'hF);

   always @(posedge I_SYS_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         state        <= ST_RESTORE;                       // RL3
         powerup      <= 1'h1;
         word_idx     <= 4'h0;
         wait_cnt     <= 17'h00000;
         wel          <= 1'h0;                             // RL1 RL7
         prl          <= 1'h0;                             // RL7
         restore_busy <= 1'h0;
         save_busy    <= 1'h0;
      end
      else
      begin
         restore_busy <= (state == ST_RESTORE);
         save_busy    <= (state == ST_SAVE) | (state == ST_WAIT);
         case (state)
            ST_IDLE:
            begin
               word_idx <= 4'h0;
               wait_cnt <= 17'h00000;
               if (!restore_n || cmd_rest)
                  state <= ST_RESTORE;
               else if (save_go)
                  state <= ST_SAVE;
               if (cmd_set)
                  wel <= 1'h1;
               else if (cmd_clear)
                  wel <= 1'h0;
            end
            ST_RESTORE:
            begin
               word_idx <= word_idx + 4'h1;
               if (last)
               begin
                  state   <= ST_IDLE;
                  powerup <= 1'h0;
                  if (!powerup)
                     prl <= 1'h1;                          // RL2 RL4
               end
            end
            ST_SAVE:
            begin
               word_idx <= word_idx + 4'h1;
               if (last)
                  state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               // copy took 16 cycles, the rest of the save time here
               wait_cnt <= wait_cnt + 17'h00001;
               if (wait_cnt >= P_SAVE_CYCLES - 17'h00011)      // RL9
               begin
                  state <= ST_IDLE;
                  wel   <= 1'h0;                           // RL14
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // arrays; contents survive reset like real cells
   wire apb_acc = I_PSEL & I_PENABLE & ~pready;
   wire in_ram  = (I_PADDR[7:6] == `NVSW_RAM_REGION);
   wire in_nv   = (I_PADDR[7:6] == `NVSW_NV_REGION);
   wire ram_wr  = apb_acc & I_PWRITE & in_ram & wel & prl &
                  (state == ST_IDLE);

   always @(posedge I_SYS_CLK)
   begin
      if (state == ST_RESTORE)
         ram_mem[word_idx] <= nv_mem[word_idx];            // RL3
      else if (ram_wr)
         ram_mem[I_PADDR[5:2]] <= I_PWDATA[15:0];
      if (state == ST_SAVE)
         nv_mem[word_idx] <= ram_mem[word_idx];
   end

   // ==========================================================
   // apb slave, one wait state on every access
   always @*
   begin
      next_prdata = 32'h00000000;
      next_err    = 1'h0;
      if (I_PADDR == `NVSW_CTRL_OFS)
         next_prdata[`NVSW_CTRL_INH_BIT] = save_inhibit;
      else if (I_PADDR == `NVSW_STAT_OFS)
      begin
         next_prdata[`NVSW_STAT_WEL_BIT] = wel;
         next_prdata[`NVSW_STAT_PRL_BIT] = prl;
         next_prdata[`NVSW_STAT_PWR_BIT] = powerup;
         next_prdata[`NVSW_STAT_SAV_BIT] = save_busy;
         next_prdata[`NVSW_STAT_RST_BIT] = restore_busy;
         next_err = I_PWRITE;
      end
      else if (in_ram)
         next_prdata[15:0] = ram_mem[I_PADDR[5:2]];
      else if (in_nv)
      begin
         next_prdata[15:0] = nv_mem[I_PADDR[5:2]];
         next_err = I_PWRITE;
      end
      else
         next_err = 1'h1;
      if (I_PWRITE)
         next_prdata = 32'h00000000;
   end

   always @(posedge I_SYS_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         pready       <= 1'h0;
         prdata       <= 32'h00000000;
         pslverr      <= 1'h0;
         save_inhibit <= `NVSW_CTRL_RST;
      end
      else
      begin
         pready  <= apb_acc;
         prdata  <= apb_acc ? next_prdata : 32'h00000000;
         pslverr <= apb_acc & next_err;
         if (apb_acc && I_PWRITE && I_PADDR == `NVSW_CTRL_OFS)
            save_inhibit <= I_PWDATA[`NVSW_CTRL_INH_BIT];
      end
   end

   assign O_PREADY        = pready;
   assign O_PRDATA        = prdata;
   assign O_PSLVERR       = pslverr;
   assign O_WRITE_LATCH   = wel;
   assign O_PRIOR_RESTORE = prl;
   assign O_RESTORE_BUSY  = restore_busy;
   assign O_SAVE_BUSY     = save_busy;
endmodule // nvsw_top

// ---- dv/nvsw_host_model.sv ----
`timescale 1ns/1ns
module nvsw_host_model
(
   input  logic i_clk,    // system clock
   output logic o_cs,     // chip select
   output logic o_sk,     // shift clock
   output logic o_si,     // serial data
   output logic o_save_n, // save pin
   output logic o_rest_n  // restore pin
);
   initial
   begin
      o_cs = 1'b0;
      o_sk = 1'b0;
      o_si = 1'b0;
      o_save_n = 1'b1;
      o_rest_n = 1'b1;
   end
   // ==========================================================
   // one instruction, msb first; clock stands still between frames
   // shift clock period 400 ns: four system clocks high, four low
   task send(input logic [7:0] op);
      int i;
      begin
         repeat (16) @(posedge i_clk);
         o_cs <= 1'b1;
         repeat (16) @(posedge i_clk);
         for (i = 7; i >= 0; i--)
         begin
            o_si <= op[i];
            repeat (4) @(posedge i_clk);
            o_sk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sk <= 1'b0;
         end
         repeat (4) @(posedge i_clk);
         o_cs <= 1'b0;
         o_si <= ~op[0]; // released line must not keep the last bit
      end
   endtask
   task pins(input logic cs, input logic sv, input logic rs);
      o_cs <= cs;
      o_save_n <= sv;
      o_rest_n <= rs;
   endtask
endmodule // nvsw_host_model

// ---- dv/nvsw_top_asserts.sv ----
`timescale 1ns/1ns
module nvsw_top_asserts
#(
   parameter [16:0] P_SAVE_CYCLES = 17'h28
)
(
   input wire logic I_SYS_CLK,       // clock
   input wire logic I_RESET,         // reset
   input wire logic I_CHIP_SELECT,   // pin
   input wire logic I_RESTORE_N,     // pin
   input wire logic I_PSEL,          // apb
   input wire logic I_PENABLE,       // apb
   input wire logic O_PREADY,        // apb
   input wire logic O_WRITE_LATCH,   // latch
   input wire logic O_PRIOR_RESTORE, // latch
   input wire logic O_RESTORE_BUSY,  // busy
   input wire logic O_SAVE_BUSY      // busy
);
   logic        pu_done;
   logic        rb_q;
   logic [16:0] save_cnt;
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);
   // ==========================================================
   // helpers
   always_ff @(posedge I_SYS_CLK or posedge I_RESET)
      if (I_RESET)
      begin
         pu_done  <= 1'b0;
         rb_q     <= 1'b0;
         save_cnt <= 17'h0;
      end
      else
      begin
         pu_done  <= pu_done | (rb_q & !O_RESTORE_BUSY);
         rb_q     <= O_RESTORE_BUSY;
         save_cnt <= O_SAVE_BUSY ? save_cnt + 17'h1 : 17'h0;
      end
   property p_pu_wel;
      !pu_done |-> !O_WRITE_LATCH;
   endproperty
   a_pu_wel: assert property (p_pu_wel)
      else $error("write latch set during power-up copy");
   property p_pu_prl;
      !pu_done |-> !O_PRIOR_RESTORE;
   endproperty
   a_pu_prl: assert property (p_pu_prl)
      else $error("prior-restore latch set by power-up copy");
   property p_prl_cause;
      $rose(O_PRIOR_RESTORE) |-> O_RESTORE_BUSY || $past(O_RESTORE_BUSY);
   endproperty
   a_prl_cause: assert property (p_prl_cause)
      else $error("prior-restore latch set without restore");
   property p_restore_len;
      $rose(O_RESTORE_BUSY) |-> O_RESTORE_BUSY[*8] ##[1:40] !O_RESTORE_BUSY;
   endproperty
   a_restore_len: assert property (p_restore_len)
      else $error("restore copy length wrong");
   property p_save_latches;
      $rose(O_SAVE_BUSY) |-> O_WRITE_LATCH && O_PRIOR_RESTORE;
   endproperty
   a_save_latches: assert property (p_save_latches)
      else $error("save started without both latches");
   property p_save_end;
      $fell(O_SAVE_BUSY) |-> !O_WRITE_LATCH;
   endproperty
   a_save_end: assert property (p_save_end)
      else $error("write latch kept after save");
   property p_save_len;
      $fell(O_SAVE_BUSY) |-> save_cnt >= P_SAVE_CYCLES - 17'h1
                          && save_cnt <= P_SAVE_CYCLES + 17'h1;
   endproperty
   a_save_len: assert property (p_save_len)
      else $error("save length wrong");
   property p_cs_block;
      (!I_CHIP_SELECT)[*8] |=> !$rose(O_SAVE_BUSY);
   endproperty
   a_cs_block: assert property (p_cs_block)
      else $error("save started with chip select low");
   property p_rst_block;
      (!I_RESTORE_N)[*8] |=> !$rose(O_SAVE_BUSY);
   endproperty
   a_rst_block: assert property (p_rst_block)
      else $error("save started with restore pin low");
   property p_ready;
      I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb ready late");
endmodule // nvsw_top_asserts
bind nvsw_top nvsw_top_asserts #(.P_SAVE_CYCLES(P_SAVE_CYCLES)) u_chk
(
   .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_CHIP_SELECT(I_CHIP_SELECT),
   .I_RESTORE_N(I_RESTORE_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
   .O_PREADY(O_PREADY), .O_WRITE_LATCH(O_WRITE_LATCH),
   .O_PRIOR_RESTORE(O_PRIOR_RESTORE), .O_RESTORE_BUSY(O_RESTORE_BUSY),
   .O_SAVE_BUSY(O_SAVE_BUSY)
);

// ---- dv/nvsw_top_tb_top.sv ----
`timescale 1ns/1ns
module nvsw_top_tb_top;
   localparam logic [16:0] save_cycles           = 17'h28; // 5 ms shortened
   localparam logic [7:0]  clear_write_latch_cmd = 8'hF8;
   localparam logic [7:0]  save_cmd              = 8'h81;
   localparam logic [7:0]  set_write_latch_cmd   = 8'hCC;
   localparam logic [7:0]  restore_cmd           = 8'hA5;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, perr;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rdata;
   wire         cs, sk, si, sv_n, rs_n, pready, pslverr, wl, prl, rb, sb;
   wire  [31:0] prdata;
   int          num_errors = 0, comparisons = 0, cycles = 0;
   always #25 clk = ~clk;
   nvsw_top #(.P_SAVE_CYCLES(save_cycles)) dut
   (
      .I_SYS_CLK(clk), .I_RESET(rst), .I_CHIP_SELECT(cs),
      .I_SERIAL_SHIFT_CLOCK(sk), .I_SERIAL_IN(si), .I_SAVE_N(sv_n),
      .I_RESTORE_N(rs_n), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
      .O_WRITE_LATCH(wl), .O_PRIOR_RESTORE(prl), .O_RESTORE_BUSY(rb),
      .O_SAVE_BUSY(sb)
   );
   nvsw_host_model host
   (
      .i_clk(clk), .o_cs(cs), .o_sk(sk), .o_si(si), .o_save_n(sv_n),
      .o_rest_n(rs_n)
   );
   task step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         psel    <= 1'b1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge clk);
         penable <= 1'b1;
         // only the bench timeout ends this wait
         do
            @(posedge clk);
         while (pready !== 1'b1);
         rdata   = prdata;
         perr    = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wait_idle;
      int n;
      begin
         n = 0;
         // pins settle in four edges; a late retrigger shows busy by eight
         step(8);
         while ((rb !== 1'b0 || sb !== 1'b0) && n < 400)
         begin
            step(1);
            n++;
         end
         chk("idle_wait", 32'(n == 400), 32'h0);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up;
      end
   end
   initial
   begin
      step(16);
      rst <= 1'b0;
      wait_idle;
      chk("wl_pu", 32'(wl), 32'h0);
      chk("prl_pu", 32'(prl), 32'h0);
      host.send(set_write_latch_cmd);
      step(8);
      chk("wl_set", 32'(wl), 32'h1);
      host.send(save_cmd);
      step(8);
      chk("save_no_prl", 32'(sb), 32'h0);
      chk("prl_other", 32'(prl), 32'h0);
      $display("test latches done");
      host.send(restore_cmd);
      wait_idle;
      chk("prl_restore", 32'(prl), 32'h1);
      apb(1'b1, 8'h40, 32'h1234);
      apb(1'b0, 8'h40, 32'h0);
      chk("ram0", rdata, 32'h1234);
      chk("ram0_err", 32'(perr), 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk("status", rdata, 32'h3);
      host.send(save_cmd);
      step(8);
      chk("save_cmd", 32'(sb), 32'h1);
      wait_idle;
      chk("wl_after_save", 32'(wl), 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk("nv0", rdata, 32'h1234);
      host.send(clear_write_latch_cmd);
      $display("test software save done");
      host.send(set_write_latch_cmd);
      step(8);
      apb(1'b1, 8'h40, 32'h5A5A);
      apb(1'b0, 8'h40, 32'h0);
      chk("ram_write", rdata, 32'h5A5A);
      host.pins(1'b0, 1'b0, 1'b1);
      step(20);
      chk("save_cs_low", 32'(sb), 32'h0);
      host.pins(1'b1, 1'b0, 1'b0);
      step(20);
      chk("save_rest_low", 32'(sb), 32'h0);
      host.pins(1'b0, 1'b1, 1'b1);
      wait_idle;
      apb(1'b0, 8'h40, 32'h0);
      chk("ram_recalled", rdata, 32'h1234);
      chk("wl_kept", 32'(wl), 32'h1);
      host.pins(1'b1, 1'b0, 1'b1);
      step(8);
      chk("save_pin", 32'(sb), 32'h1);
      host.pins(1'b0, 1'b1, 1'b1);
      wait_idle;
      chk("wl_hw_save", 32'(wl), 32'h0);
      host.send(set_write_latch_cmd);
      host.send(clear_write_latch_cmd);
      step(8);
      chk("wl_clear", 32'(wl), 32'h0);
      $display("test pins done");
      apb(1'b1, 8'h40, 32'hFFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk("ram_locked", rdata, 32'h1234);
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'(perr), 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      chk("status_ro", 32'(perr), 32'h1);
      apb(1'b1, 8'h84, 32'h1);
      chk("nv_ro", 32'(perr), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl_rst", rdata, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl_inhibit", rdata, 32'h1);
      host.send(set_write_latch_cmd);
      host.send(save_cmd);
      step(8);
      chk("save_inhibited", 32'(sb), 32'h0);
      chk("wl_inhibited", 32'(wl), 32'h1);
      apb(1'b1, 8'h00, 32'h0);
      $display("test apb done");
      rst <= 1'b1;
      step(2);
      rst <= 1'b0;
      wait_idle;
      apb(1'b0, 8'h40, 32'h0);
      chk("pu_copy", rdata, 32'h1234);
      chk("pu_latches", 32'({wl, prl}), 32'h0);
      $display("test power-up done");
      wrap_up;
   end
endmodule // nvsw_top_tb_top
